// *** pkg/adcss_pkg.sv ***
// Overview of operation
// - External ascending mode converts channels zero up to index, serial-paced, no averaging.
// - Upper modes convert index up to top input; internal averages, external does not.
// - Custom modes convert listed channels once, ascending, at most 16; internal averages.
// - Free-order mode walks up to 256 list entries, external pacing, no averaging.
// - Free-order list entries are unrestricted: repeats and any order allowed.
// - Scan codes 1010 to 1111 keep the previous mode and ignore low bits.
// - Channel index is plain binary; 0 to 15 select inputs zero to fifteen.
// - Scan code zero keeps the current mode and ignores the low eleven bits.
package adcss_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CUSTOM = 8'h04;
  localparam logic [7:0] OFF_LIST_LEN = 8'h08;
  localparam logic [7:0] OFF_LIST_ADDR = 8'h0C;
  localparam logic [7:0] OFF_LIST_DATA = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CMD_SCAN_LSB = 11;
  localparam int CMD_CHAN_LSB = 7;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLR_DONE_BIT = 1;
  localparam int CTRL_PART_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_SCAN_LSB = 4;
  localparam int ST_ACT_CHAN_LSB = 8;
  localparam int ST_CUR_CHAN_LSB = 12;
  localparam int ST_COUNT_LSB = 16;

  // ------------------------------------------------------------
  // Scan-select codes
  // ------------------------------------------------------------
  localparam logic [3:0] SCAN_HOLD = 4'h0;
  localparam logic [3:0] SCAN_MANUAL = 4'h1;
  localparam logic [3:0] SCAN_REPEAT = 4'h2;
  localparam logic [3:0] SCAN_STD_INT = 4'h3;
  localparam logic [3:0] SCAN_STD_EXT = 4'h4;
  localparam logic [3:0] SCAN_UPPER_INT = 4'h5;
  localparam logic [3:0] SCAN_UPPER_EXT = 4'h6;
  localparam logic [3:0] SCAN_CUSTOM_INT = 4'h7;
  localparam logic [3:0] SCAN_CUSTOM_EXT = 4'h8;
  localparam logic [3:0] SCAN_FREE = 4'h9;
  localparam logic [3:0] SCAN_LAST_VALID = 4'h9;

  // ------------------------------------------------------------
  // Part sizes and input masks
  // ------------------------------------------------------------
  localparam logic [1:0] PART_16 = 2'h0;
  localparam logic [1:0] PART_8 = 2'h1;
  localparam logic [15:0] INPUT_MASK_16 = 16'hFFFF;
  localparam logic [15:0] INPUT_MASK_8 = 16'h00FF;
  localparam logic [15:0] INPUT_MASK_4 = 16'h000F;
  localparam int LIST_DEPTH = 256;
  localparam int NUM_INPUTS = 16;

  // ------------------------------------------------------------
  // Reset values and bus answers
  // ------------------------------------------------------------
  localparam logic [3:0] RST_SCAN = 4'h4;
  localparam logic [3:0] RST_CHAN = 4'h0;
  localparam logic [15:0] RST_CUSTOM = 16'h0000;
  localparam logic [7:0] RST_LIST_LEN = 8'h00;
  localparam logic [1:0] RST_PART = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCSS_S_IDLE = 3'h1,
    ADCSS_S_ISSUE = 3'h2,
    ADCSS_S_WAIT = 3'h4
  } adcss_state_t;

  typedef struct packed {
    logic [3:0] channel;
    logic average;
    logic internal_clk;
  } adcss_conv_t;

endpackage

// *** design/adcss_lowest_bit.sv ***
`timescale 1ns/1ns
// Finds the lowest set bit of a channel mask
module adcss_lowest_bit (
  input logic [15:0] mask,
  output logic found,
  output logic [3:0] index
);

  logic [15:0] below;
  logic [15:0] pick;

  // ------------------------------------------------------------
  // Priority chain, one stage per input
  // ------------------------------------------------------------
  genvar i;
  for (i = 0; i < adcss_pkg::NUM_INPUTS; i++) begin : g_bit
    if (i == 0) begin : g_first
      assign below[i] = 1'b0;
    end else begin : g_rest
      assign below[i] = below[i-1] | mask[i-1];
    end
    assign pick[i] = mask[i] & ~below[i];
  end

  // Pick is one-hot, so OR of indices is the index
  always_comb begin
    index = 4'h0;
    for (int k = 0; k < adcss_pkg::NUM_INPUTS; k++) begin
      if (pick[k]) begin
        index = index | 4'(k);
      end
    end
  end

  assign found = |mask;

endmodule // adcss_lowest_bit

// *** design/adcss_scan_sequencer.sv ***
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module adcss_scan_sequencer (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic ext_pace_pin,
  input logic conv_done,
  output logic conv_req,
  output adcss_pkg::adcss_conv_t conv,
  output logic scan_busy,
  output logic scan_done
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic aw_held, w_held, do_write, start_req, clr_done;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, wr_merged, wmask;
  logic [3:0] wr_strb, new_scan, new_chan;
  logic [3:0] pend_scan, pend_chan, act_scan, act_chan, cur_chan;
  logic [15:0] custom_mask, rem;
  logic [7:0] list_len_m1, list_addr;
  logic [3:0] list_mem [adcss_pkg::LIST_DEPTH];
  logic [1:0] part_sel;
  logic [8:0] idx, res_count;
  logic done_flag, pace_s1, pace_s2, pace_s3, pace_edge;
  logic found, more, step_ok, act_internal, act_free, cmd_wr, cmd_valid;
  logic [3:0] found_idx, next_chan;
  adcss_pkg::adcss_state_t state;

  function automatic logic is_internal(input logic [3:0] s);
    return s == adcss_pkg::SCAN_REPEAT || s == adcss_pkg::SCAN_STD_INT ||
           s == adcss_pkg::SCAN_UPPER_INT || s == adcss_pkg::SCAN_CUSTOM_INT;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a inside {adcss_pkg::OFF_CMD, adcss_pkg::OFF_CUSTOM, adcss_pkg::OFF_LIST_LEN,
                     adcss_pkg::OFF_LIST_ADDR, adcss_pkg::OFF_LIST_DATA,
                     adcss_pkg::OFF_CTRL, adcss_pkg::OFF_STATUS};
  endfunction

  // Read view of every register, shared by reads and write merges
  function automatic logic [31:0] regval(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      adcss_pkg::OFF_CMD: begin
        r = (32'(pend_scan) << adcss_pkg::CMD_SCAN_LSB) |
            (32'(pend_chan) << adcss_pkg::CMD_CHAN_LSB);
      end
      adcss_pkg::OFF_CUSTOM: r = 32'(custom_mask);
      adcss_pkg::OFF_LIST_LEN: r = 32'(list_len_m1);
      adcss_pkg::OFF_LIST_ADDR: r = 32'(list_addr);
      adcss_pkg::OFF_LIST_DATA: r = 32'(list_mem[list_addr]);
      adcss_pkg::OFF_CTRL: r = 32'(part_sel) << adcss_pkg::CTRL_PART_LSB;
      adcss_pkg::OFF_STATUS: begin
        r = (32'(scan_busy) << adcss_pkg::ST_BUSY_BIT) |
            (32'(done_flag) << adcss_pkg::ST_DONE_BIT) |
            (32'(act_scan) << adcss_pkg::ST_SCAN_LSB) |
            (32'(act_chan) << adcss_pkg::ST_ACT_CHAN_LSB) |
            (32'(cur_chan) << adcss_pkg::ST_CUR_CHAN_LSB) |
            (32'(res_count) << adcss_pkg::ST_COUNT_LSB);
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Channel set of a mask-driven scan, clipped to the inputs of part p
  function automatic logic [15:0] scan_mask(input logic [3:0] s, input logic [3:0] n,
                                            input logic [1:0] p);
    logic [15:0] m;
    logic [15:0] lim;
    m = 16'h0000;
    for (int k = 0; k < adcss_pkg::NUM_INPUTS; k++) begin
      case (s)
        adcss_pkg::SCAN_STD_INT, adcss_pkg::SCAN_STD_EXT: m[k] = (k <= int'(n));
        adcss_pkg::SCAN_UPPER_INT, adcss_pkg::SCAN_UPPER_EXT: m[k] = (k >= int'(n));
        adcss_pkg::SCAN_CUSTOM_INT, adcss_pkg::SCAN_CUSTOM_EXT: m[k] = custom_mask[k];
        default: m[k] = (k == int'(n));
      endcase
    end
    case (p)
      adcss_pkg::PART_16: lim = adcss_pkg::INPUT_MASK_16;
      adcss_pkg::PART_8: lim = adcss_pkg::INPUT_MASK_8;
      default: lim = adcss_pkg::INPUT_MASK_4;
    endcase
    return m & lim;
  endfunction

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  // Address and data may arrive in either order; held until both present
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_merged = (regval(wr_addr) & ~wmask) | (wr_data & wmask);
  assign new_scan = wr_merged[adcss_pkg::CMD_SCAN_LSB +: 4];
  assign new_chan = wr_merged[adcss_pkg::CMD_CHAN_LSB +: 4];
  assign cmd_wr = do_write && wr_addr == adcss_pkg::OFF_CMD;
  assign cmd_valid = new_scan != adcss_pkg::SCAN_HOLD && new_scan <= adcss_pkg::SCAN_LAST_VALID;
  assign start_req = do_write && wr_addr == adcss_pkg::OFF_CTRL &&
                     wr_merged[adcss_pkg::CTRL_START_BIT];
  assign clr_done = do_write && wr_addr == adcss_pkg::OFF_CTRL &&
                    wr_merged[adcss_pkg::CTRL_CLR_DONE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adcss_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? adcss_pkg::RESP_OKAY : adcss_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adcss_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= regval(s_axi_araddr);
      s_axi_rresp <= is_mapped(s_axi_araddr) ? adcss_pkg::RESP_OKAY : adcss_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Command only stages the mode; a running scan keeps its own copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_scan <= adcss_pkg::RST_SCAN;
      pend_chan <= adcss_pkg::RST_CHAN;
      custom_mask <= adcss_pkg::RST_CUSTOM;
      list_len_m1 <= adcss_pkg::RST_LIST_LEN;
      list_addr <= 8'h00;
      part_sel <= adcss_pkg::RST_PART;
      for (int k = 0; k < adcss_pkg::LIST_DEPTH; k++) begin
        list_mem[k] <= 4'h0;
      end
    end else if (do_write) begin
      case (wr_addr)
        adcss_pkg::OFF_CMD: begin
          if (cmd_valid) begin
            pend_scan <= new_scan;
            pend_chan <= new_chan;
          end
        end
        adcss_pkg::OFF_CUSTOM: custom_mask <= wr_merged[15:0];
        adcss_pkg::OFF_LIST_LEN: list_len_m1 <= wr_merged[7:0];
        adcss_pkg::OFF_LIST_ADDR: list_addr <= wr_merged[7:0];
        adcss_pkg::OFF_LIST_DATA: begin
          // Any channel, any order, repeats allowed
          list_mem[list_addr] <= wr_merged[3:0];
          list_addr <= list_addr + 8'h01;
        end
        adcss_pkg::OFF_CTRL: part_sel <= wr_merged[adcss_pkg::CTRL_PART_LSB +: 2];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Serial pace pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace_s1 <= 1'b0;
      pace_s2 <= 1'b0;
      pace_s3 <= 1'b0;
    end else begin
      pace_s1 <= ext_pace_pin;
      pace_s2 <= pace_s1;
      pace_s3 <= pace_s2;
    end
  end
  assign pace_edge = pace_s2 && !pace_s3;

  // ------------------------------------------------------------
  // Scan walker
  // ------------------------------------------------------------
  adcss_lowest_bit u_lowest (
    .mask(rem),
    .found(found),
    .index(found_idx)
  );

  assign act_internal = is_internal(act_scan);
  assign act_free = act_scan == adcss_pkg::SCAN_FREE;
  assign next_chan = act_free ? list_mem[idx[7:0]] : found_idx;
  assign more = act_free ? (idx <= {1'b0, list_len_m1}) : found;
  // External modes advance only on a pace edge
  assign step_ok = act_internal || pace_edge;
  assign scan_busy = state != adcss_pkg::ADCSS_S_IDLE;

  // Sequence state; start is ignored while a scan runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= adcss_pkg::ADCSS_S_IDLE;
      act_scan <= adcss_pkg::RST_SCAN;
      act_chan <= adcss_pkg::RST_CHAN;
      cur_chan <= 4'h0;
      rem <= 16'h0000;
      idx <= 9'h000;
      res_count <= 9'h000;
      conv_req <= 1'b0;
      conv <= '0;
      scan_done <= 1'b0;
    end else begin
      conv_req <= 1'b0;
      scan_done <= 1'b0;
      case (state)
        adcss_pkg::ADCSS_S_IDLE: begin
          if (start_req) begin
            act_scan <= pend_scan;
            act_chan <= pend_chan;
            // Part size from the start word itself, so one write sizes and starts
            rem <= scan_mask(pend_scan, pend_chan,
                             wr_merged[adcss_pkg::CTRL_PART_LSB +: 2]);
            idx <= 9'h000;
            res_count <= 9'h000;
            state <= adcss_pkg::ADCSS_S_ISSUE;
          end
        end
        adcss_pkg::ADCSS_S_ISSUE: begin
          if (!more) begin
            scan_done <= 1'b1;
            state <= adcss_pkg::ADCSS_S_IDLE;
          end else if (step_ok) begin
            conv_req <= 1'b1;
            conv.channel <= next_chan;
            conv.average <= act_internal;
            conv.internal_clk <= act_internal;
            cur_chan <= next_chan;
            if (act_free) begin
              idx <= idx + 9'h001;
            end else begin
              rem[found_idx] <= 1'b0;
            end
            state <= adcss_pkg::ADCSS_S_WAIT;
          end
        end
        adcss_pkg::ADCSS_S_WAIT: begin
          if (conv_done) begin
            res_count <= res_count + 9'h001;
            state <= adcss_pkg::ADCSS_S_ISSUE;
          end
        end
        default: state <= adcss_pkg::ADCSS_S_IDLE;
      endcase
    end
  end

  // Sticky done; a new end of scan beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag <= 1'b0;
    end else if (scan_done) begin
      done_flag <= 1'b1;
    end else if (clr_done) begin
      done_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [3:0] last_chan;
  logic issued_any;

  // Last channel issued in the current scan, for order checks
  always_ff @(posedge aclk) begin
    if (!aresetn || state == adcss_pkg::ADCSS_S_IDLE) begin
      last_chan <= 4'h0;
      issued_any <= 1'b0;
    end else if (conv_req) begin
      last_chan <= conv.channel;
      issued_any <= 1'b1;
    end
  end

  chk_hold_code: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && new_scan == adcss_pkg::SCAN_HOLD |=> $stable(pend_scan) && $stable(pend_chan))
    else $error("hold code changed the staged mode");
  chk_unused_code: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && new_scan > adcss_pkg::SCAN_LAST_VALID |=> $stable(pend_scan) && $stable(pend_chan))
    else $error("unassigned code changed the staged mode");
  chk_latch_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && cmd_valid |=> pend_scan == $past(new_scan) && pend_chan == $past(new_chan))
    else $error("valid command not staged");
  chk_apply_start: assert property (@(posedge aclk) disable iff (!aresetn)
    state == adcss_pkg::ADCSS_S_IDLE && start_req
    |=> act_scan == $past(pend_scan) && act_chan == $past(pend_chan) ##1 (scan_busy || scan_done))
    else $error("staged mode not applied at scan start");
  chk_std_range: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_req && act_scan == adcss_pkg::SCAN_STD_EXT |-> conv.channel <= act_chan && !conv.average)
    else $error("ascending scan left its range");
  chk_upper_range: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_req && (act_scan == adcss_pkg::SCAN_UPPER_INT || act_scan == adcss_pkg::SCAN_UPPER_EXT)
    |-> conv.channel >= act_chan && conv.average == (act_scan == adcss_pkg::SCAN_UPPER_INT))
    else $error("upper scan below index or wrong averaging");
  chk_custom_order: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_req && issued_any && (act_scan == adcss_pkg::SCAN_CUSTOM_INT ||
    act_scan == adcss_pkg::SCAN_CUSTOM_EXT || act_scan == adcss_pkg::SCAN_STD_EXT)
    |-> conv.channel > last_chan)
    else $error("list scan not strictly ascending");
  chk_free_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_req && act_free |-> conv.channel == list_mem[idx[7:0] - 8'h01] &&
    !conv.average && !conv.internal_clk)
    else $error("free list entry not issued as stored");
  chk_ext_pace: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_req && !conv.internal_clk |-> $past(pace_edge))
    else $error("external-clock conversion without pace edge");
  chk_bus_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 1'b1 |=> s_axi_bvalid)
    else $error("write response late");

endmodule // adcss_scan_sequencer

// *** verification/adcss_conv_model.sv ***
`timescale 1ns/1ns
// Converter stand-in: answers each request once, alternately fast and slow
module adcss_conv_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_req,
  output logic conv_done
);
  logic busy;
  logic slow;
  logic [1:0] wait_cnt;

  // Done only after a request; the 1 or 3 cycle delay exercises both paces
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      slow <= 1'b0;
      wait_cnt <= 2'h0;
      conv_done <= 1'b0;
    end else if (conv_req) begin
      busy <= 1'b1;
      slow <= !slow;
      wait_cnt <= slow ? 2'h3 : 2'h1;
      conv_done <= 1'b0;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 2'h1;
      busy <= (wait_cnt != 2'h1);
      conv_done <= (wait_cnt == 2'h1);
    end else begin
      conv_done <= 1'b0;
    end
  end
endmodule // adcss_conv_model

// *** verification/adc_scan_sequencer_tb.sv ***
`timescale 1ns/1ns
module adc_scan_sequencer_tb;
  logic aclk, aresetn, ext_pace_pin, conv_done, conv_req, scan_busy, scan_done;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pace_cnt;
  adcss_pkg::adcss_conv_t conv;
  adcss_pkg::adcss_conv_t got_q[$];
  adcss_pkg::adcss_conv_t exp_q[$];
  logic [3:0] fl [5] = '{4'h9, 4'h3, 4'h9, 4'h3, 4'h0};
  int failures, samples_checked;

  adcss_scan_sequencer adcss_scan_sequencer_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_pace_pin, .conv_done, .conv_req, .conv, .scan_busy, .scan_done);
  adcss_conv_model adcss_conv_model_inst (.aclk, .aresetn, .conv_req, .conv_done);

  // Clock, 8 ns period
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Pace pin rises every 8 cycles, only while a scan runs
  always @(posedge aclk) begin
    pace_cnt <= pace_cnt + 2'h1;
    if (pace_cnt == 2'h3) ext_pace_pin <= !ext_pace_pin && (scan_busy === 1'b1);
  end
  // Log requests mid-cycle, away from the launching edge
  always @(negedge aclk) if (conv_req === 1'b1) got_q.push_back(conv);

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_conv(input adcss_pkg::adcss_conv_t g, input adcss_pkg::adcss_conv_t e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Decide on the settled negedge, act at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && (s_axi_awready === 1'b1);
      w_t = s_axi_wvalid && (s_axi_wready === 1'b1);
      b_t = (s_axi_bvalid === 1'b1);
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && (s_axi_arready === 1'b1);
      r_t = (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  function automatic logic [31:0] cmdw(input logic [3:0] s, input logic [3:0] n);
    return {17'h0, s, n, 7'h0};
  endfunction
  task automatic push_exp(input logic [3:0] c, input logic a);
    exp_q.push_back(adcss_pkg::adcss_conv_t'{channel: c, average: a, internal_clk: a});
  endtask
  // One scan: order and flags of every request, then the result count
  task automatic run_scan(input logic [31:0] cmd, input logic [31:0] ctrl);
    int n;
    axi_wr(adcss_pkg::OFF_CMD, cmd);
    got_q.delete();
    axi_wr(adcss_pkg::OFF_CTRL, ctrl);
    chk_resp(rsp, adcss_pkg::RESP_OKAY);
    n = 0;
    while (scan_done !== 1'b1 && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    if (n == 3000) failures++;
    chk_word(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) chk_conv(got_q[i], exp_q[i]);
    axi_rd(adcss_pkg::OFF_STATUS);
    chk_word({23'h0, rd[24:16]}, 32'(exp_q.size()));
    chk_word({30'h0, rd[1:0]}, 32'h2);
    $display("scan test done, %0d results", exp_q.size());
  endtask
  task automatic final_report;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {failures, samples_checked, pace_cnt, ext_pace_pin, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(adcss_pkg::OFF_CMD);
    chk_word(rd, cmdw(adcss_pkg::RST_SCAN, adcss_pkg::RST_CHAN));
    axi_rd(8'h40);
    chk_resp(rsp, adcss_pkg::RESP_SLVERR);
    for (int i = 0; i < 3; i++) push_exp(4'(i), 1'b0);
    run_scan(cmdw(adcss_pkg::SCAN_STD_EXT, 4'h2), 32'h1);
    exp_q.delete();
    for (int i = 0; i < 2; i++) push_exp(4'(i), 1'b1);
    run_scan(cmdw(adcss_pkg::SCAN_STD_INT, 4'h1), 32'h1);
    // Internal upper mode on each part size, over the top three inputs
    for (int p = 0; p < 3; p++) begin
      exp_q.delete();
      for (int c = (16 >> p) - 3; c < (16 >> p); c++) push_exp(4'(c), 1'b1);
      run_scan(cmdw(adcss_pkg::SCAN_UPPER_INT, 4'((16 >> p) - 3)), {26'h0, 2'(p), 4'h1});
    end
    exp_q.delete();
    push_exp(4'he, 1'b0);
    push_exp(4'hf, 1'b0);
    run_scan(cmdw(adcss_pkg::SCAN_UPPER_EXT, 4'he), 32'h1);
    axi_wr(adcss_pkg::OFF_CUSTOM, 32'h8421);
    exp_q.delete();
    for (int c = 0; c < 16; c += 5) push_exp(4'(c), 1'b1);
    run_scan(cmdw(adcss_pkg::SCAN_CUSTOM_INT, 4'h0), 32'h1);
    axi_wr(adcss_pkg::OFF_CUSTOM, 32'h6);
    exp_q.delete();
    push_exp(4'h1, 1'b0);
    push_exp(4'h2, 1'b0);
    run_scan(cmdw(adcss_pkg::SCAN_CUSTOM_EXT, 4'h0), 32'h1);
    // Free-order list with repeats and a falling order
    axi_wr(adcss_pkg::OFF_LIST_LEN, 32'h4);
    axi_wr(adcss_pkg::OFF_LIST_ADDR, 32'h0);
    exp_q.delete();
    foreach (fl[i]) begin
      axi_wr(adcss_pkg::OFF_LIST_DATA, {28'h0, fl[i]});
      push_exp(fl[i], 1'b0);
    end
    run_scan(cmdw(adcss_pkg::SCAN_FREE, 4'h0), 32'h1);
    axi_wr(adcss_pkg::OFF_LIST_ADDR, 32'h1);
    axi_rd(adcss_pkg::OFF_LIST_DATA);
    chk_word(rd, 32'h3);
    // Unassigned codes and code zero leave the staged command alone
    for (int s = 10; s <= 16; s++) begin
      axi_wr(adcss_pkg::OFF_CMD, cmdw(4'(s), 4'h7));
      axi_rd(adcss_pkg::OFF_CMD);
      chk_word(rd, cmdw(adcss_pkg::SCAN_FREE, 4'h0));
    end
    run_scan(cmdw(adcss_pkg::SCAN_HOLD, 4'h7), 32'h1);
    final_report;
  end
  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    final_report;
  end
endmodule // adc_scan_sequencer_tb
